// ==== hw/hwmon_sequencer.sv ====
// Measurement sequencer, limit checker and AHB-Lite register file.
//
// Decided for this implementation: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps
module hwmon_sequencer
   import hwmon_pkg::*;
(
   input wire logic sys_clk_in,
   input wire logic reset_n_in,
   input wire logic hsel_in,
   input wire logic [31:0] haddr_in,
   input wire logic [1:0] htrans_in,
   input wire logic hwrite_in,
   input wire logic [2:0] hsize_in,
   input wire logic [31:0] hwdata_in,
   input wire logic hready_in,
   output logic [31:0] hrdata_out,
   output logic hreadyout_out,
   output logic hresp_out,
   output logic adc_start_out,
   output logic [3:0] adc_chan_out,
   output logic adc_vcc5_out,
   output logic adc_diode2_out,
   input wire logic adc_done_in,
   input wire logic [DATA_W-1:0] adc_data_in,
   input wire logic tach_or_analog_in_a_in,
   input wire logic tach_or_analog_in_b_in,
   input wire logic core_vcode_msb_pin_in,
   input wire logic [3:0] core_vcode_low_pins_in,
   output logic irq_out,
   output logic int_oe_n_out
);
   typedef struct packed {
      logic wr_pend;
      logic [7:0] wr_addr;
      logic [31:0] rdata;
      logic ready;
      logic resp;
      logic irq;
      logic oe_n;
      logic [1:0] cfg;
      logic [3:0] chmode;
      logic [7:0] fandiv;
      logic [INT_W-1:0] status;
      logic [INT_W-1:0] mask;
      logic vcode_msb;
      logic [3:0] vcode_low;
      logic [4:0] ext_irq_input_en;
      logic [4:0] vcode_s1;
      logic [4:0] vcode_s2;
      logic [1:0] tach_s1;
      logic [1:0] tach_s2;
      seq_type seq;
      logic [3:0] chan;
      logic start;
      logic [TICK_W-1:0] tick_cnt;
      logic tick;
      logic [NUM_VAL-1:0][DATA_W-1:0] value;
      logic [NUM_VAL-1:0][DATA_W-1:0] lim_hi;
      logic [NUM_VAL-1:0][DATA_W-1:0] lim_lo;
   } seq_state_type;

   seq_state_type s_q, s_d;
   logic [INT_W-1:0] sets;
   logic [INT_W-1:0] clr;
   logic [DATA_W-1:0] meas;
   logic [3:0] idx;
   logic [7:0] raddr;
   logic [1:0] fan_en;
   logic [1:0] fan_done;
   logic [1:0][FAN_W-1:0] fan_cnt;

   // A channel is skipped when its pin serves another purpose.
   function automatic logic skip_chan(input logic [3:0] c,
                                      input logic [3:0] m);
      skip_chan = (c == CH_AIN_A && m[CHM_FAN_A_BIT]) ||
                  (c == CH_AIN_B && m[CHM_FAN_B_BIT]) ||
                  (c == CH_AUX && m[CHM_DIODE2_BIT]);
   endfunction

   function automatic logic [3:0] step_chan(input logic [3:0] c);
      step_chan = (c == CH_LAST) ? 4'h0 : c + 4'h1;
   endfunction

   function automatic logic [3:0] next_chan(input logic [3:0] c,
                                            input logic [3:0] m);
      logic [3:0] r;
      r = step_chan(c);
      for (int k = 0; k < 3; k++) begin
         if (skip_chan(r, m)) begin
            r = step_chan(r);
         end
      end
      next_chan = r;
   endfunction

   assign hrdata_out = s_q.rdata;
   assign hreadyout_out = s_q.ready;
   assign hresp_out = s_q.resp;
   assign adc_start_out = s_q.start;
   assign adc_chan_out = s_q.chan;
   assign adc_vcc5_out = s_q.chmode[CHM_VCC5_BIT];
   assign adc_diode2_out = s_q.chmode[CHM_DIODE2_BIT];
   assign irq_out = s_q.irq;
   assign int_oe_n_out = s_q.oe_n;

   assign fan_en[0] = s_q.chmode[CHM_FAN_A_BIT] &
                      s_q.cfg[CFG_START_BIT];
   assign fan_en[1] = s_q.chmode[CHM_FAN_B_BIT] &
                      s_q.cfg[CFG_START_BIT];

   // Fans run beside the converter cycle and never stall it.
   tach_meter fan_a (
      .sys_clk_in(sys_clk_in),
      .reset_n_in(reset_n_in),
      .enable_in(fan_en[0]),
      .tach_in(s_q.tach_s2[0]),
      .tick_in(s_q.tick),
      .div_sel_in(s_q.fandiv[FD_DIV_A +: 2]),
      .ppr_sel_in(s_q.fandiv[FD_PPR_A +: 2]),
      .count_out(fan_cnt[0]),
      .done_out(fan_done[0])
   );

   tach_meter fan_b (
      .sys_clk_in(sys_clk_in),
      .reset_n_in(reset_n_in),
      .enable_in(fan_en[1]),
      .tach_in(s_q.tach_s2[1]),
      .tick_in(s_q.tick),
      .div_sel_in(s_q.fandiv[FD_DIV_B +: 2]),
      .ppr_sel_in(s_q.fandiv[FD_PPR_B +: 2]),
      .count_out(fan_cnt[1]),
      .done_out(fan_done[1])
   );

   always_comb begin
      s_d = s_q;
      sets = '0;
      clr = '0;
      meas = '0;
      idx = 4'h0;
      raddr = haddr_in[7:0];
      s_d.start = 1'b0;

      // Pins pass two flip-flops before anything reads them.
      s_d.vcode_s1 = {core_vcode_msb_pin_in, core_vcode_low_pins_in};
      s_d.vcode_s2 = s_q.vcode_s1;
      s_d.tach_s1 = {tach_or_analog_in_b_in, tach_or_analog_in_a_in};
      s_d.tach_s2 = s_q.tach_s1;
      s_d.vcode_msb = s_q.vcode_s2[4];
      s_d.vcode_low = s_q.vcode_s2[3:0];

      // A pin in interrupt use requests while it is held low.
      sets[ST_VCODE +: 5] = s_q.ext_irq_input_en &
                            ~s_q.vcode_s2;

      if (s_q.tick_cnt == TACH_TICK_CYC - 1'b1) begin
         s_d.tick_cnt = '0;
         s_d.tick = 1'b1;
      end else begin
         s_d.tick_cnt = s_q.tick_cnt + 1'b1;
         s_d.tick = 1'b0;
      end

      for (int f = 0; f < 2; f++) begin
         if (fan_done[f]) begin
            s_d.value[FAN_VAL_BASE + f] = DATA_W'(fan_cnt[f]);
            if (DATA_W'(fan_cnt[f]) >
                s_q.lim_hi[FAN_VAL_BASE + f]) begin
               sets[ST_FAN_A + f] = 1'b1;
            end
         end
      end

      case (s_q.seq)
         SEQ_IDLE: begin
            if (s_q.cfg[CFG_START_BIT]) begin
               s_d.chan = 4'h0;
               s_d.start = 1'b1;
               s_d.seq = SEQ_WAIT;
            end
         end
         SEQ_WAIT: begin
            if (adc_done_in) begin
               // Channel 9 is the on-chip sensor, 6 the second diode.
               meas = adc_data_in;
               s_d.value[s_q.chan] = meas;
               if (meas > s_q.lim_hi[s_q.chan] ||
                   meas < s_q.lim_lo[s_q.chan]) begin
                  sets[s_q.chan] = 1'b1;
               end
               s_d.chan = next_chan(s_q.chan, s_q.chmode);
               if (s_q.cfg[CFG_START_BIT]) begin
                  s_d.start = 1'b1;
               end else begin
                  s_d.seq = SEQ_IDLE;
               end
            end
         end
         default: begin
            s_d.seq = SEQ_IDLE;
         end
      endcase

      // Data phase of a write taken in the previous cycle.
      if (s_q.wr_pend) begin
         if (s_q.wr_addr == REG_CONFIG) begin
            s_d.cfg = hwdata_in[1:0];
         end else if (s_q.wr_addr == REG_CHMODE) begin
            s_d.chmode = hwdata_in[3:0];
         end else if (s_q.wr_addr == REG_FANDIV) begin
            s_d.fandiv = hwdata_in[7:0];
         end else if (s_q.wr_addr == REG_STATUS) begin
            clr = hwdata_in[INT_W-1:0];
         end else if (s_q.wr_addr == REG_MASK) begin
            s_d.mask = hwdata_in[INT_W-1:0];
         end else if (s_q.wr_addr == REG_EXT_IRQ) begin
            s_d.ext_irq_input_en = hwdata_in[4:0];
         end else if (s_q.wr_addr >= REG_LIMIT_BASE &&
                      s_q.wr_addr < REG_LIMIT_END) begin
            idx = s_q.wr_addr[6:3];
            if (s_q.wr_addr[2]) begin
               s_d.lim_lo[idx] = hwdata_in[DATA_W-1:0];
            end else begin
               s_d.lim_hi[idx] = hwdata_in[DATA_W-1:0];
            end
         end
      end

      // Address phase; reads are answered with zero wait states.
      s_d.wr_pend = 1'b0;
      s_d.rdata = '0;
      if (hsel_in && hready_in && htrans_in[1]) begin
         if (hwrite_in) begin
            s_d.wr_pend = 1'b1;
            s_d.wr_addr = raddr;
         end else if (raddr == REG_CONFIG) begin
            s_d.rdata = 32'(s_q.cfg);
         end else if (raddr == REG_CHMODE) begin
            s_d.rdata = 32'(s_q.chmode);
         end else if (raddr == REG_FANDIV) begin
            s_d.rdata = 32'(s_q.fandiv);
         end else if (raddr == REG_STATUS) begin
            s_d.rdata = 32'(s_q.status);
         end else if (raddr == REG_MASK) begin
            s_d.rdata = 32'(s_q.mask);
         end else if (raddr == REG_VCODE_MSB) begin
            s_d.rdata = 32'(s_q.vcode_msb);
         end else if (raddr == REG_VCODE_LOW) begin
            s_d.rdata = 32'(s_q.vcode_low);
         end else if (raddr == REG_EXT_IRQ) begin
            s_d.rdata = 32'(s_q.ext_irq_input_en);
         end else if (raddr >= REG_VALUE_BASE &&
                      raddr < REG_VALUE_END) begin
            idx = raddr[5:2];
            s_d.rdata = 32'(s_q.value[idx]);
         end else if (raddr >= REG_LIMIT_BASE &&
                      raddr < REG_LIMIT_END) begin
            idx = raddr[6:3];
            if (raddr[2]) begin
               s_d.rdata = 32'(s_q.lim_lo[idx]);
            end else begin
               s_d.rdata = 32'(s_q.lim_hi[idx]);
            end
         end
      end

      // A new event beats a clear landing in the same cycle.
      s_d.status = (s_q.status & ~clr) | sets;
      // The level follows masked status and the enable bit, so it drops when
      // no unmasked bit is set or the enable bit is cleared.
      s_d.irq = (|(s_d.status & s_d.mask)) &
                s_d.cfg[CFG_INT_EN_BIT];
      s_d.oe_n = ~s_d.irq;
      s_d.ready = 1'b1;
      s_d.resp = 1'b0;
   end

   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         s_q <= '0;
         s_q.ready <= 1'b1;
         s_q.oe_n <= 1'b1;
         s_q.cfg <= CFG_RESET;
         s_q.chmode <= CHMODE_RESET;
         s_q.fandiv <= FANDIV_RESET;
         s_q.seq <= SEQ_IDLE;
         s_q.lim_hi <= {NUM_VAL{LIMIT_HI_RESET}};
         s_q.lim_lo <= {NUM_VAL{LIMIT_LO_RESET}};
      end else begin
         s_q <= s_d;
      end
   end
endmodule // hwmon_sequencer

// ==== hw/hwmon_pkg.sv ====
// Constants and types shared by the measurement sequencer and fan meters.
// Functional notes
// - One shared ten-bit converter digitises all channels.
// - Pins a/b select analog channel or tachometer.
// - Fan divisor and pulses per revolution programmable.
// - Pin pair: two voltages or second diode.
// - On-chip temperature sensor is a converter source.
// - Channel mode bit 3 selects 3.3/5 V scaling.
// - Started monitoring steps channels in fixed round-robin.
// - Tachometers measured concurrently, independent of sequence.
// - Each result lands in its own value register.
// - Out-of-limit results set interrupt status bits.
// - Recorded out-of-limit status raises the interrupt.
// - Mask register suppresses chosen status bits.
// - Code pins captured in two readable registers.
// - Each code pin may act as interrupt input.
// - Interrupt driver only when enable bit set.
package hwmon_pkg;
   localparam int DATA_W = 10;
   localparam int NUM_VAL = 12;
   localparam int FAN_W = 8;
   localparam int INT_W = 17;
   localparam logic [7:0] REG_CONFIG = 8'h00;
   localparam logic [7:0] REG_CHMODE = 8'h04;
   localparam logic [7:0] REG_FANDIV = 8'h08;
   localparam logic [7:0] REG_STATUS = 8'h0C;
   localparam logic [7:0] REG_MASK = 8'h10;
   localparam logic [7:0] REG_VCODE_MSB = 8'h14;
   localparam logic [7:0] REG_VCODE_LOW = 8'h18;
   localparam logic [7:0] REG_EXT_IRQ = 8'h1C;
   localparam logic [7:0] REG_VALUE_BASE = 8'h40;
   localparam logic [7:0] REG_VALUE_END = 8'h70;
   localparam logic [7:0] REG_LIMIT_BASE = 8'h80;
   localparam logic [7:0] REG_LIMIT_END = 8'hE0;
   localparam int CFG_START_BIT = 0;
   localparam int CFG_INT_EN_BIT = 1;
   localparam logic [1:0] CFG_RESET = 2'h0;
   localparam int CHM_FAN_A_BIT = 0;
   localparam int CHM_FAN_B_BIT = 1;
   localparam int CHM_DIODE2_BIT = 2;
   localparam int CHM_VCC5_BIT = 3;
   localparam logic [3:0] CHMODE_RESET = 4'h0;
   localparam int FD_DIV_A = 0;
   localparam int FD_DIV_B = 2;
   localparam int FD_PPR_A = 4;
   localparam int FD_PPR_B = 6;
   localparam logic [7:0] FANDIV_RESET = 8'h50;
   localparam int ST_FAN_A = 10;
   localparam int ST_VCODE = 12;
   localparam logic [3:0] CH_AIN_A = 4'h4;
   localparam logic [3:0] CH_AIN_B = 4'h5;
   localparam logic [3:0] CH_AUX = 4'h7;
   localparam logic [3:0] CH_LAST = 4'h9;
   localparam int FAN_VAL_BASE = 10;
   localparam logic [DATA_W-1:0] LIMIT_HI_RESET = 10'h3FF;
   localparam logic [DATA_W-1:0] LIMIT_LO_RESET = 10'h000;
   localparam int SYS_CLK_KHZ = 40000;
   localparam int TACH_TICK_NS = 22500;
   localparam int TICK_W = 10;
   localparam logic [TICK_W-1:0] TACH_TICK_CYC =
      TICK_W'((TACH_TICK_NS * SYS_CLK_KHZ) / 1000000);
   typedef enum logic [1:0] {SEQ_IDLE, SEQ_WAIT} seq_type;
endpackage

// ==== hw/tach_meter.sv ====
// Fan tachometer period meter counting prescaled ticks per revolution.
`timescale 1ns/1ps
module tach_meter
   import hwmon_pkg::*;
(
   input wire logic sys_clk_in,
   input wire logic reset_n_in,
   input wire logic enable_in,
   input wire logic tach_in,
   input wire logic tick_in,
   input wire logic [1:0] div_sel_in,
   input wire logic [1:0] ppr_sel_in,
   output logic [FAN_W-1:0] count_out,
   output logic done_out
);
   typedef struct packed {
      logic prev;
      logic armed;
      logic [1:0] edges;
      logic [2:0] pre;
      logic [FAN_W-1:0] cnt;
      logic [FAN_W-1:0] result;
      logic done;
   } tach_type;
   tach_type s_q, s_d;
   logic rise;
   logic [2:0] pre_max;

   assign count_out = s_q.result;
   assign done_out = s_q.done;

   always_comb begin
      s_d = s_q;
      s_d.done = 1'b0;
      s_d.prev = tach_in;
      rise = tach_in & ~s_q.prev;
      pre_max = 3'((4'h1 << div_sel_in) - 4'h1);
      if (!enable_in) begin
         s_d.armed = 1'b0;
      end else if (rise && !s_q.armed) begin
         s_d.armed = 1'b1;
         s_d.edges = 2'h0;
         s_d.cnt = '0;
         s_d.pre = 3'h0;
      end else if (rise && s_q.edges == ppr_sel_in) begin
         s_d.result = s_q.cnt;
         s_d.done = 1'b1;
         s_d.edges = 2'h0;
         s_d.cnt = '0;
         s_d.pre = 3'h0;
      end else begin
         if (rise) begin
            s_d.edges = s_q.edges + 2'h1;
         end
         if (tick_in && s_q.armed) begin
            s_d.pre = s_q.pre + 3'h1;
            if (s_q.pre == pre_max) begin
               s_d.pre = 3'h0;
               if (&s_q.cnt) begin
                  // A stalled fan reports full scale and disarms until the next rising edge.
                  s_d.result = s_q.cnt;
                  s_d.done = 1'b1;
                  s_d.armed = 1'b0;
               end else begin
                  s_d.cnt = s_q.cnt + 1'b1;
               end
            end
         end
      end
   end

   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
endmodule // tach_meter

// ==== testbench/hwmon_monitor.sv ====
// Port checker for the sequencer's bus, converter and interrupt outputs.
`timescale 1ns/1ps
module hwmon_monitor
   import hwmon_pkg::*;
(
   input wire logic sys_clk_in,
   input wire logic reset_n_in,
   input wire logic hsel_in,
   input wire logic [31:0] haddr_in,
   input wire logic [1:0] htrans_in,
   input wire logic hwrite_in,
   input wire logic [2:0] hsize_in,
   input wire logic [31:0] hwdata_in,
   input wire logic hready_in,
   input wire logic [31:0] hrdata_out,
   input wire logic hreadyout_out,
   input wire logic hresp_out,
   input wire logic adc_start_out,
   input wire logic [3:0] adc_chan_out,
   input wire logic adc_vcc5_out,
   input wire logic adc_diode2_out,
   input wire logic adc_done_in,
   input wire logic [DATA_W-1:0] adc_data_in,
   input wire logic tach_or_analog_in_a_in,
   input wire logic tach_or_analog_in_b_in,
   input wire logic core_vcode_msb_pin_in,
   input wire logic [3:0] core_vcode_low_pins_in,
   input wire logic irq_out,
   input wire logic int_oe_n_out
);
   logic take;
   logic wr_take;
   logic chm_take;
   assign take = hsel_in & hready_in & htrans_in[1];
   assign wr_take = take & hwrite_in;
   assign chm_take = wr_take & (haddr_in[7:0] == REG_CHMODE);
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!reset_n_in);
   a_bus_ready_okay: assert property (hreadyout_out && !hresp_out)
      else $error("bus slave stalled or answered with an error");
   a_read_idle_zero: assert property (!(take && !hwrite_in) |=>
      hrdata_out == 32'h0) else $error("read data outside a read");
   a_mode_by_write: assert property ($changed({adc_vcc5_out,
      adc_diode2_out}) |-> $past(chm_take, 2))
      else $error("scaling mode changed without a mode write");
   a_irq_falls_write: assert property ($fell(irq_out) |->
      $past(wr_take, 2)) else $error("interrupt dropped without a write");
   a_start_has_cause: assert property ($rose(adc_start_out) |->
      $past(adc_done_in) || $past(wr_take, 2) || $past(wr_take, 3))
      else $error("conversion started without cause");
   a_start_one_cycle: assert property (adc_start_out |=> !adc_start_out)
      else $error("start pulse longer than one cycle");
   a_start_chan_range: assert property (adc_start_out |->
      adc_chan_out <= CH_LAST) else $error("channel beyond last");
   a_oe_follows_irq: assert property (int_oe_n_out == !irq_out)
      else $error("pin enable disagrees with interrupt");
endmodule // hwmon_monitor
bind hwmon_sequencer hwmon_monitor mon (.sys_clk_in(sys_clk_in),
   .reset_n_in(reset_n_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
   .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(hsize_in),
   .hwdata_in(hwdata_in), .hready_in(hready_in), .hrdata_out(hrdata_out),
   .hreadyout_out(hreadyout_out), .hresp_out(hresp_out),
   .adc_start_out(adc_start_out), .adc_chan_out(adc_chan_out),
   .adc_vcc5_out(adc_vcc5_out), .adc_diode2_out(adc_diode2_out),
   .adc_done_in(adc_done_in), .adc_data_in(adc_data_in),
   .tach_or_analog_in_a_in(tach_or_analog_in_a_in),
   .tach_or_analog_in_b_in(tach_or_analog_in_b_in),
   .core_vcode_msb_pin_in(core_vcode_msb_pin_in),
   .core_vcode_low_pins_in(core_vcode_low_pins_in),
   .irq_out(irq_out), .int_oe_n_out(int_oe_n_out));

// ==== testbench/adc_model.sv ====
// Converter stand-in that answers each start pulse after a set latency.
`timescale 1ns/1ps
module adc_model
   import hwmon_pkg::*;
(
   input wire logic sys_clk_in,
   input wire logic reset_n_in,
   input wire logic adc_start_in,
   input wire logic [3:0] adc_chan_in,
   input wire logic [7:0] latency_in,
   output logic adc_done_out,
   output logic [DATA_W-1:0] adc_data_out
);
   logic [7:0] cnt;
   logic busy;
   logic [3:0] chan;
   always @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         cnt <= 8'h00;
         busy <= 1'b0;
         chan <= 4'h0;
         adc_done_out <= 1'b0;
         adc_data_out <= 10'h155;
      end else begin
         adc_done_out <= 1'b0;
         // Data toggles when not valid so a stale sample never matches.
         adc_data_out <= ~adc_data_out;
         if (adc_start_in) begin
            busy <= 1'b1;
            cnt <= latency_in;
            chan <= adc_chan_in;
         end else if (busy && cnt <= 8'h01) begin
            busy <= 1'b0;
            adc_done_out <= 1'b1;
            adc_data_out <= {chan, 6'h15};
         end else if (busy) begin
            cnt <= cnt - 8'h01;
         end
      end
   end
endmodule // adc_model

// ==== testbench/tb.sv ====
// Self-checking bench for the measurement sequencer.
`timescale 1ns/1ps
module tb
   import hwmon_pkg::*;
;
   logic sys_clk_in = 1'b0;
   logic reset_n_in = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic [31:0] rd;
   logic hreadyout, hresp, adc_start, vcc5, diode2, adc_done, irq, oe_n;
   logic [3:0] chan;
   logic [DATA_W-1:0] adc_data;
   logic tach = 1'b0;
   logic tach_en = 1'b0;
   logic [3:0] vlow = 4'hA;
   logic vmsb = 1'b1;
   logic [7:0] lat = 8'h01;
   logic [3:0] seq[$];
   int num_errors = 0;
   int total_checks = 0;
   int cycles = 0;
   localparam logic [31:0] RA[8] = '{32'h0, 32'h4, 32'h8, 32'hC, 32'h10,
      32'h80, 32'h84, 32'h3C};
   localparam logic [31:0] RV[8] = '{32'h0, 32'h0, 32'h50, 32'h0, 32'h0,
      32'h3FF, 32'h0, 32'h0};
   localparam logic [31:0] SA[6] = '{32'h10, 32'h10, 32'h0, 32'h0, 32'hC,
      32'hC};
   localparam logic [31:0] SD[6] = '{32'h0, 32'hC, 32'h0, 32'h2, 32'h4,
      32'h8};
   localparam logic SE[6] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
   localparam logic [31:0] SO[8] = '{32'h0, 32'h1, 32'h2, 32'h3, 32'h6,
      32'h8, 32'h9, 32'h0};
   hwmon_sequencer uut (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
      .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
      .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
      .hready_in(hreadyout), .hrdata_out(hrdata),
      .hreadyout_out(hreadyout), .hresp_out(hresp),
      .adc_start_out(adc_start), .adc_chan_out(chan),
      .adc_vcc5_out(vcc5), .adc_diode2_out(diode2),
      .adc_done_in(adc_done), .adc_data_in(adc_data),
      .tach_or_analog_in_a_in(tach), .tach_or_analog_in_b_in(tach),
      .core_vcode_msb_pin_in(vmsb), .core_vcode_low_pins_in(vlow),
      .irq_out(irq), .int_oe_n_out(oe_n));
   adc_model adc (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
      .adc_start_in(adc_start), .adc_chan_in(chan), .latency_in(lat),
      .adc_done_out(adc_done), .adc_data_out(adc_data));
   always #12.5 sys_clk_in = ~sys_clk_in;
   always begin
      repeat (1350) @(posedge sys_clk_in);
      if (tach_en) tach <= ~tach;
   end
   always @(posedge sys_clk_in) begin
      if (adc_start === 1'b1) seq.push_back(chan);
      cycles <= cycles + 1;
      if (cycles == 90000) begin
         num_errors++;
         results();
      end
   end
   task automatic results();
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, g);
      total_checks++;
      if (g !== e) begin
         num_errors++;
         $display("ERROR %s expected %0h seen %0h", n, e, g);
      end
   endtask
   task automatic chk_bit(input string n, input logic e, g);
      chk(n, {31'h0, e}, {31'h0, g});
   endtask
   task automatic chk_range(input string n, input int lo, hi);
      total_checks++;
      if ((rd >= 32'(lo) && rd <= 32'(hi)) !== 1'b1) begin
         num_errors++;
         $display("ERROR %s expected %0d..%0d seen %0h", n, lo, hi, rd);
      end
   endtask
   // The master never assumes a latency: it waits for ready each phase.
   task automatic ahb(input logic w, input logic [31:0] a, d);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge sys_clk_in); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge sys_clk_in); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   task automatic wr(input logic [31:0] a, d);
      ahb(1'b1, a, d);
   endtask
   task automatic rdchk(input string n, input logic [31:0] a, m, e);
      ahb(1'b0, a, 32'h0);
      chk(n, e, rd & m);
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge sys_clk_in);
   endtask
   initial begin
      wt(16);
      reset_n_in <= 1'b1;
      wt(1);
      chk_bit("oe_n", 1'b1, oe_n);
      for (int i = 0; i < 8; i++) rdchk("reset value", RA[i],
         32'hFFFFFFFF, RV[i]);
      wr(32'h90, 32'h90);
      wr(32'h9C, 32'h12C);
      wr(REG_MASK, 32'hC);
      wr(REG_CONFIG, 32'h3);
      wt(200);
      for (int i = 0; i < 10; i++) chk("order", 32'(i), {28'h0, seq[i]});
      for (int i = 0; i < 10; i++) rdchk("value", 32'(REG_VALUE_BASE) +
         32'(4 * i), 32'hFFFFFFFF, {22'h0, i[3:0], 6'h15});
      rdchk("status", REG_STATUS, 32'h1FFFF, 32'hC);
      chk_bit("irq", 1'b1, irq);
      wr(REG_CONFIG, 32'h2);
      wt(50);
      for (int i = 0; i < 6; i++) begin
         wr(SA[i], SD[i]);
         wt(3);
         chk_bit("irq", SE[i], irq);
         chk_bit("oe_n", !SE[i], oe_n);
      end
      wr(REG_CHMODE, 32'hF);
      lat <= 8'h14;
      seq.delete();
      wr(REG_CONFIG, 32'h1);
      wt(300);
      chk_bit("vcc5 scale", 1'b1, vcc5);
      chk_bit("diode2", 1'b1, diode2);
      for (int i = 0; i < 8; i++) chk("skip order", SO[i],
         {28'h0, seq[i]});
      wr(REG_CONFIG, 32'h0);
      wt(60);
      rdchk("code msb", REG_VCODE_MSB, 32'hFFFFFFFF, 32'h1);
      rdchk("code low", REG_VCODE_LOW, 32'hFFFFFFFF, 32'hA);
      vmsb <= 1'b0;
      wt(5);
      rdchk("code msb low", REG_VCODE_MSB, 32'hFFFFFFFF, 32'h0);
      wr(REG_EXT_IRQ, 32'h1);
      wr(REG_MASK, 32'h1000);
      wr(REG_CONFIG, 32'h2);
      wt(5);
      rdchk("pin status", REG_STATUS, 32'h1000, 32'h1000);
      chk_bit("irq", 1'b1, irq);
      vlow <= 4'hF;
      wt(5);
      wr(REG_STATUS, 32'h1000);
      wt(3);
      chk_bit("irq", 1'b0, irq);
      wr(REG_CHMODE, 32'h3);
      wr(32'hD0, 32'h5);
      wr(REG_MASK, 32'h400);
      wr(REG_CONFIG, 32'h3);
      tach_en <= 1'b1;
      wt(12000);
      ahb(1'b0, 32'h68, 32'h0);
      chk_range("fan count", 5, 7);
      ahb(1'b0, 32'h6C, 32'h0);
      chk_range("fan b count", 5, 7);
      wr(REG_FANDIV, 32'h70);
      wt(24000);
      ahb(1'b0, 32'h68, 32'h0);
      chk_range("fan count", 11, 13);
      rdchk("fan status", REG_STATUS, 32'h400, 32'h400);
      chk_bit("irq", 1'b1, irq);
      // A divider of two halves the count for the same fan speed.
      wr(REG_FANDIV, 32'h71);
      wt(24000);
      ahb(1'b0, 32'h68, 32'h0);
      chk_range("fan divided", 5, 7);
      results();
   end
endmodule // tb
